// ### rtl/cbsi_pkg.sv
package cbsi_pkg;
  // Whole opcodes: the first six are decoded whole, the last three are used by the checks only
  localparam logic [7:0] OP_IRET = 8'h80;
  localparam logic [7:0] OP_RTS = 8'h81;
  localparam logic [7:0] OP_STOP = 8'h8e;
  localparam logic [7:0] OP_SEC = 8'h99;
  localparam logic [7:0] OP_IMASK = 8'h9b;
  localparam logic [7:0] OP_SPRST = 8'h9c;
  localparam logic [7:0] OP_BRA = 8'h20;
  localparam logic [7:0] OP_SUB_IMM = 8'ha0;
  localparam logic [7:0] OP_SBB_IMM = 8'ha2;
  // Low nibble of the memory-operand groups
  localparam logic [3:0] LO_SUB = 4'h0;
  localparam logic [3:0] LO_SBB = 4'h2;
  localparam logic [3:0] LO_RRC = 4'h6;
  localparam logic [3:0] LO_STACC = 4'h7;
  localparam logic [3:0] LO_JUMP = 4'hc;
  localparam logic [3:0] LO_CALL = 4'hd;
  localparam logic [3:0] LO_STIDX = 4'hf;
  // Stack and direct page
  localparam logic [7:0] SP_TOP = 8'hff;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  // Stack walk index: pops run 0..4, push of the high byte is 5
  localparam logic [2:0] PK_FLAGS = 3'h0;
  localparam logic [2:0] PK_PCH = 3'h3;
  localparam logic [2:0] PK_PCL = 3'h4;
  localparam logic [2:0] PK_PUSH_HI = 3'h5;
  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_START = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_PC = 8'h0c;
  localparam logic [7:0] A_REGS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CTRL_RUN = 0;
  localparam int ST_STOP = 0;
  localparam int ST_ILL = 1;
  localparam int ST_BUSY = 2;
  localparam logic [15:0] START_PC_RST = 16'h0000;

  typedef enum logic [2:0] {S_IDLE = 3'b000, S_FETCH = 3'b001, S_OPND = 3'b010, S_ACCESS = 3'b011,
    S_STACK = 3'b100, S_PAD = 3'b101, S_STOP = 3'b110} cbsi_state_t;
  typedef enum logic [3:0] {M_INH = 4'h0, M_IMM = 4'h1, M_DIR = 4'h2, M_EXT = 4'h3, M_IX2 = 4'h4,
    M_IX1 = 4'h5, M_IX = 4'h6, M_REL = 4'h7, M_BTB = 4'h8} cbsi_mode_t;
  typedef enum logic [3:0] {G_ILL = 4'h0, G_BTB = 4'h1, G_REL = 4'h2, G_SUB = 4'h3, G_SBB = 4'h4,
    G_STACC = 4'h5, G_STIDX = 4'h6, G_JUMP = 4'h7, G_CALL = 4'h8, G_RRC = 4'h9, G_SPRST = 4'ha,
    G_IRET = 4'hb, G_RTS = 4'hc, G_IMASK = 4'hd, G_SEC = 4'he, G_STOP = 4'hf} cbsi_grp_t;

  // Addressing mode from the high nibble
  function automatic cbsi_mode_t op_mode(input logic [7:0] op);
    case (op[7:4])
      4'h0: return M_BTB;
      4'h2: return M_REL;
      4'h3, 4'hb: return M_DIR;
      4'h6, 4'he: return M_IX1;
      4'h7, 4'hf: return M_IX;
      4'ha: return M_IMM;
      4'hc: return M_EXT;
      4'hd: return M_IX2;
      default: return M_INH;
    endcase
  endfunction

  // Instruction group; anything outside the subset is illegal
  function automatic cbsi_grp_t op_group(input logic [7:0] op);
    if (op[7:4] == 4'h0) return G_BTB;
    if (op[7:4] == 4'h2) return G_REL;
    if (op == OP_IRET) return G_IRET;
    if (op == OP_RTS) return G_RTS;
    if (op == OP_STOP) return G_STOP;
    if (op == OP_SEC) return G_SEC;
    if (op == OP_IMASK) return G_IMASK;
    if (op == OP_SPRST) return G_SPRST;
    if (op[3:0] == LO_RRC && op[7:4] >= 4'h3 && op[7:4] <= 4'h7) return G_RRC;
    if (op[7:4] < 4'ha) return G_ILL;
    case (op[3:0])
      LO_SUB: return G_SUB;
      LO_SBB: return G_SBB;
      LO_STACC: return (op[7:4] == 4'ha) ? G_ILL : G_STACC;
      LO_STIDX: return (op[7:4] == 4'ha) ? G_ILL : G_STIDX;
      LO_JUMP: return (op[7:4] == 4'ha) ? G_ILL : G_JUMP;
      LO_CALL: return (op[7:4] == 4'ha) ? G_ILL : G_CALL;
      default: return G_ILL;
    endcase
  endfunction

  // Operand bytes following the opcode
  function automatic logic [3:0] opnd_bytes(input cbsi_mode_t m);
    case (m)
      M_BTB, M_EXT, M_IX2: return 4'h2;
      M_IMM, M_DIR, M_IX1, M_REL: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction

  // Cycle count of each instruction; memory-operand groups derive from the load table, the rest are fixed
  function automatic logic [3:0] op_cycles(input cbsi_grp_t g, input cbsi_mode_t m);
    logic [3:0] b;
    case (m)
      M_IMM: b = 4'h2;
      M_DIR, M_IX: b = 4'h3;
      M_EXT, M_IX1: b = 4'h4;
      M_IX2: b = 4'h5;
      default: b = 4'h0;
    endcase
    case (g)
      G_SUB, G_SBB: return b;
      G_STACC, G_STIDX: return b + 4'h1;
      G_JUMP: return b - 4'h1;
      G_CALL: return b + 4'h2;
      G_RRC: return (m == M_INH) ? 4'h3 : b + 4'h2;
      G_IRET, G_RTS: return 4'h6;
      G_BTB: return 4'h5;
      G_REL: return 4'h3;
      default: return 4'h2;
    endcase
  endfunction

  // Sign-extend a relative offset
  function automatic logic [15:0] sext(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  // Conditional branch test: pair base condition, odd opcode inverts
  function automatic logic branch_ok(input logic [7:0] op, input logic h, input logic i,
                                     input logic n, input logic z, input logic c, input logic pin);
    logic b;
    case (op[3:1])
      3'h0: b = 1'b1;
      3'h1: b = ~(c | z);
      3'h2: b = ~c;
      3'h3: b = ~z;
      3'h4: b = ~h;
      3'h5: b = ~n;
      3'h6: b = ~i;
      default: b = ~pin;
    endcase
    return op[0] ? ~b : b;
  endfunction
endpackage

// ### rtl/cbsi_core.sv
`timescale 1ns/1ps
// Functional notes
// - Bit-test branches reach the first 256 bytes
// - Bit-test branch: opcode, direct address, offset
// - Bit number and sense come from opcode
// - Taken branch: next address plus signed offset
// - Tested bit always copied into carry
// - Conditional branches redirect only when true
// - Jumps take target from the effective address, X added in indexed modes
// - Rotate right through carry, N Z C
// - Stack reset loads 0x00FF, flags kept
// - Interrupt return pops five bytes, six cycles
// - Subroutine return pops PC high then low
// - Subtract with borrow updates N Z C
// - Mask set raises I only
// - Accumulator store updates N Z, not C
// - Stop halts oscillator, enables pin, clears I
// - Index store updates N Z, not C
// - Subtract updates accumulator and N Z C
module cbsi_core
  import cbsi_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite write channels
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read channels
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Program and data memory, read data valid in the same cycle
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input logic [7:0] mem_rdata,
  // Pins
  input logic irq_pin,
  output logic osc_stop,
  output logic irq_pin_en
);

  ////////////////////////////////////////////////////////////////////////////
  // All state in one record
  typedef struct packed {
    cbsi_state_t st;
    logic [7:0] op;
    logic [3:0] cyc, tgt, left;
    logic [2:0] pk;
    logic [15:0] pc, ea, start_pc, maddr;
    logic [7:0] a, x, sp, rel, wd;
    logic h, i, n, z, c;
    logic stop, irq_en, ill, run, irq_m1, irq_s, we;
    logic aw_got, w_got, awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
  } cbsi_regs_t;

  cbsi_regs_t r, n;
  logic [7:0] cur_op; // Opcode of the instruction under way
  logic [7:0] ain; // ALU operand
  logic [7:0] res; // ALU result
  logic cout; // ALU carry out
  logic go; // Operands complete, act this cycle
  logic do_alu; // ALU result commits this cycle
  logic [15:0] eff; // Effective address
  logic [15:0] ob; // Two operand bytes
  logic [15:0] npc; // Address of the next byte
  cbsi_grp_t g;
  cbsi_mode_t md;
  logic test_bit; // Bit picked by a bit-test opcode

  assign test_bit = mem_rdata[r.op[3:1]];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    n = r;
    go = 1'b0;
    do_alu = 1'b0;
    cur_op = (r.st == S_FETCH) ? mem_rdata : r.op;
    g = op_group(cur_op);
    md = op_mode(cur_op);
    npc = r.pc + 16'h1;
    ob = {r.ea[7:0], mem_rdata};
    // Pin synchroniser; the first stage feeds only the second
    n.irq_m1 = irq_pin;
    n.irq_s = r.irq_m1;
    n.we = 1'b0;
    n.cyc = r.cyc + 4'h1;
    // Effective address at the last operand byte
    case (md)
      M_DIR: eff = {ZERO_PAGE, mem_rdata};
      M_EXT: eff = ob;
      M_IX2: eff = ob + {8'h00, r.x};
      M_IX1: eff = {8'h00, mem_rdata} + {8'h00, r.x};
      M_IX: eff = {8'h00, r.x};
      M_BTB: eff = {ZERO_PAGE, r.ea[7:0]};
      default: eff = 16'h0000;
    endcase

    // Write channel: address and data land in either order
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (r.awready && s_axi_awvalid)
    begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (r.wready && s_axi_wvalid)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (n.aw_got && n.w_got && !n.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (n.awaddr)
        A_CTRL: if (n.wstrb[0]) n.run = n.wdata[CTRL_RUN];
        A_START:
        begin
          if (n.wstrb[0]) n.start_pc[7:0] = n.wdata[7:0];
          if (n.wstrb[1]) n.start_pc[15:8] = n.wdata[15:8];
        end
        // Sticky flag, write one to clear; a same-cycle set wins below
        A_STATUS: if (n.wstrb[0] && n.wdata[ST_ILL]) n.ill = 1'b0;
        A_PC, A_REGS: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (r.arready && s_axi_arvalid)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (s_axi_araddr)
        A_CTRL: n.rdata = {31'h0, r.run};
        A_START: n.rdata = {16'h0, r.start_pc};
        A_STATUS: n.rdata = {29'h0, r.st != S_IDLE, r.ill, r.stop};
        A_PC: n.rdata = {16'h0, r.pc};
        A_REGS: n.rdata = {3'h0, r.h, r.i, r.n, r.z, r.c, r.sp, r.x, r.a};
        default:
        begin
          n.rdata = 32'h0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Sequencer
    unique case (r.st)
      S_IDLE:
      begin
        n.pc = r.start_pc;
        n.maddr = r.start_pc;
        n.cyc = 4'h0;
        if (r.run)
          n.st = S_FETCH;
      end
      S_FETCH:
      begin
        n.op = mem_rdata;
        n.pc = npc;
        n.tgt = op_cycles(g, md);
        n.left = opnd_bytes(md);
        if (opnd_bytes(md) == 4'h0)
          go = 1'b1;
        else
        begin
          n.st = S_OPND;
          n.maddr = npc;
        end
      end
      S_OPND:
      begin
        n.pc = npc;
        n.ea = ob;
        n.left = r.left - 4'h1;
        if (r.left == 4'h1)
          go = 1'b1;
        else
          n.maddr = npc;
      end
      S_ACCESS:
      begin
        n.st = S_PAD;
        if (g == G_BTB)
        begin
          n.c = test_bit;
          if (test_bit != r.op[0])
            n.pc = r.pc + sext(r.rel);
        end
        else
          do_alu = 1'b1;
      end
      S_STACK:
      begin
        if (r.pk == PK_PUSH_HI)
        begin
          // Second push of a subroutine call, then take the target
          n.we = 1'b1;
          n.maddr = {ZERO_PAGE, r.sp};
          n.wd = r.pc[15:8];
          n.sp = r.sp - 8'h1;
          n.pc = r.ea;
          n.st = S_PAD;
        end
        else
        begin
          case (r.pk)
            PK_FLAGS: {n.h, n.i, n.n, n.z, n.c} = mem_rdata[4:0];
            3'h1: n.a = mem_rdata;
            3'h2: n.x = mem_rdata;
            PK_PCH: n.pc[15:8] = mem_rdata;
            default: n.pc[7:0] = mem_rdata;
          endcase
          if (r.pk == PK_PCL)
            n.st = S_PAD;
          else
          begin
            n.pk = r.pk + 3'h1;
            n.sp = r.sp + 8'h1;
            n.maddr = {ZERO_PAGE, r.sp + 8'h1};
          end
        end
      end
      S_PAD: n.st = S_PAD;
      S_STOP:
      begin
        n.cyc = 4'h0;
        // Clock held until the pin goes low
        if (!r.irq_s)
        begin
          n.stop = 1'b0;
          n.st = S_FETCH;
        end
      end
      default: n.st = S_IDLE;
    endcase

    // Act once every operand byte is in
    if (go)
    begin
      n.st = S_PAD;
      case (g)
        G_SUB, G_SBB:
          if (md == M_IMM)
            do_alu = 1'b1;
          else
          begin
            n.maddr = eff;
            n.st = S_ACCESS;
          end
        G_RRC:
          if (md == M_INH)
            do_alu = 1'b1;
          else
          begin
            n.maddr = eff;
            n.st = S_ACCESS;
          end
        G_BTB:
        begin
          n.rel = mem_rdata;
          n.maddr = eff;
          n.st = S_ACCESS;
        end
        G_STACC, G_STIDX:
        begin
          n.we = 1'b1;
          n.maddr = eff;
          n.wd = (g == G_STACC) ? r.a : r.x;
          n.n = n.wd[7];
          n.z = (n.wd == 8'h00);
        end
        G_REL:
          if (branch_ok(cur_op, r.h, r.i, r.n, r.z, r.c, r.irq_s))
            n.pc = npc + sext(mem_rdata);
        G_JUMP: n.pc = eff;
        G_CALL:
        begin
          n.we = 1'b1;
          n.maddr = {ZERO_PAGE, r.sp};
          n.wd = npc[7:0];
          n.sp = r.sp - 8'h1;
          n.ea = eff;
          n.pk = PK_PUSH_HI;
          n.st = S_STACK;
        end
        G_IRET, G_RTS:
        begin
          // Pre-increment before every pop
          n.pk = (g == G_IRET) ? PK_FLAGS : PK_PCH;
          n.sp = r.sp + 8'h1;
          n.maddr = {ZERO_PAGE, r.sp + 8'h1};
          n.st = S_STACK;
        end
        G_SPRST: n.sp = SP_TOP;
        G_IMASK: n.i = 1'b1;
        G_SEC: n.c = 1'b1;
        G_STOP:
        begin
          n.i = 1'b0;
          n.irq_en = 1'b1;
        end
        default: n.ill = 1'b1;
      endcase
    end

    // Shared ALU: subtract, subtract with borrow, rotate
    ain = (md == M_INH) ? (cur_op[4] ? r.x : r.a) : mem_rdata;
    if (g == G_RRC)
      {res, cout} = {r.c, ain};
    else
      {cout, res} = {1'b0, r.a} - {1'b0, ain} - {8'h00, (g == G_SBB) && r.c};
    if (do_alu)
    begin
      n.n = res[7];
      n.z = (res == 8'h00);
      n.c = cout;
      if (g != G_RRC)
        n.a = res;
      else if (md != M_INH)
      begin
        // Read-modify-write: result goes back to the same address
        n.we = 1'b1;
        n.wd = res;
      end
      else if (cur_op[4])
        n.x = res;
      else
        n.a = res;
    end

    // Last cycle of the count: pad ends, next fetch or halt follows
    if (n.st == S_PAD && r.st != S_FETCH && r.cyc == r.tgt - 4'h1)
    begin
      n.cyc = 4'h0;
      n.maddr = n.pc;
      if (!r.run)
        n.st = S_IDLE;
      else if (g == G_STOP)
      begin
        n.stop = 1'b1;
        n.st = S_STOP;
      end
      else
        n.st = S_FETCH;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; I set at reset, SP loaded with the top, start address with its reset value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.sp <= SP_TOP;
      r.i <= 1'b1;
      r.start_pc <= START_PC_RST;
    end
    else
      r <= n;
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign mem_addr = r.maddr;
  assign mem_wdata = r.wd;
  assign mem_we = r.we;
  assign osc_stop = r.stop;
  assign irq_pin_en = r.irq_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_fetch(logic [7:0] o);
    r.st == S_FETCH && mem_rdata == o;
  endsequence
  sequence s_iret_body;
    (r.st != S_FETCH && r.run) [*5];
  endsequence

  a_sprst_sp_top: assert property (s_fetch(OP_SPRST) |=> r.sp == SP_TOP && $stable({r.h, r.i, r.n, r.z, r.c}))
    else $error("stack reset wrong");
  a_iret_six_cycles: assert property (s_fetch(OP_IRET) ##1 s_iret_body |=> r.st == S_FETCH)
    else $error("interrupt return length wrong");
  a_imask_set: assert property (s_fetch(OP_IMASK) |=> r.i && $stable({r.h, r.n, r.z, r.c}))
    else $error("mask set wrong");
  a_stop_enters: assert property (s_fetch(OP_STOP) ##1 r.run |=> !r.i && r.stop && r.irq_en)
    else $error("stop wrong");
  a_sub_imm_res: assert property (s_fetch(OP_SUB_IMM) ##1 1'b1 |=>
    r.a == 8'($past(r.a) - $past(mem_rdata)) && r.c == ($past(mem_rdata) > $past(r.a)))
    else $error("subtract wrong");
  a_sbb_imm_res: assert property (s_fetch(OP_SBB_IMM) ##1 1'b1 |=>
    r.a == 8'($past(r.a) - $past(mem_rdata) - {7'h0, $past(r.c)}))
    else $error("subtract with borrow wrong");
  a_btb_carry_copy: assert property (r.st == S_ACCESS && r.op[7:4] == 4'h0 |=> r.c == $past(test_bit))
    else $error("tested bit not in carry");
  a_stacc_data_flags: assert property (r.we && r.op[3:0] == LO_STACC |-> r.wd == r.a && r.z == (r.a == 8'h00))
    else $error("accumulator store wrong");
  a_stidx_data_flags: assert property (r.we && r.op[3:0] == LO_STIDX |-> r.wd == r.x && r.n == r.x[7])
    else $error("index store wrong");
  a_bra_target: assert property (r.st == S_OPND && r.op == OP_BRA |=>
    r.pc == $past(r.pc) + 16'h1 + sext($past(mem_rdata)))
    else $error("branch target wrong");

endmodule // cbsi_core

// ### verif/cbsi_mem_model.sv
`timescale 1ns/1ps
// Program and data memory on the far side of the core
module cbsi_mem_model (
  // Clock
  input logic aclk,
  // Memory port
  input logic [15:0] mem_addr,
  input logic [7:0] mem_wdata,
  input logic mem_we,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535]; // Byte store, preloaded by the bench

  ////////////////////////////////////////////////////////////////
  // Read is combinational because the core samples it in the same cycle
  assign mem_rdata = mem[mem_addr];

  // Write lands at the edge that ends the strobe cycle
  always @(posedge aclk)
  begin
    if (mem_we)
    begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule // cbsi_mem_model

// ### verif/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench;
  import cbsi_pkg::*;
  // Clock, reset and pins
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic irq_pin = 1'h1;
  logic osc_stop, irq_pin_en, mem_we;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  // Bus master side
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0; // Mismatches
  int n_compared = 0; // Comparisons made

  // 50 MHz clock
  always #10 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////
  cbsi_core cbsi_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mem_addr, .mem_wdata, .mem_we, .mem_rdata, .irq_pin,
    .osc_stop, .irq_pin_en);
  cbsi_mem_model cbsi_mem_model_inst (.aclk, .mem_addr, .mem_wdata, .mem_we, .mem_rdata);

  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Synchronous reset held two cycles
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (!s_axi_awvalid && !s_axi_wvalid && s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask

  // Read: rready stays up until rvalid is sampled
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (!s_axi_arvalid && s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask

  // Reference outcome of one program pass: {H,I,N,Z,C,SP,X,A}, rotated byte, branch taken
  function automatic void ref_run(input logic [7:0] a, x, i1, i2, cc, op,
                                  output logic [28:0] regs, output logic [7:0] m, output logic tk);
    logic [8:0] s;
    logic c, b;
    s = {1'h0, a} - {1'h0, i1};
    c = s[8];
    s = {1'h0, s[7:0]} - {1'h0, i2} - {8'h00, c};
    c = s[8];
    m = {c, s[7:1]};
    b = m[op[3:1]];
    tk = op[0] ? ~b : b;
    regs = {cc[4], 1'h0, x[7], x == 8'h00, b, 8'hff, x, s[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] a0, x0, ii, jj, cc, op, em;
    logic [7:0] prog [27];
    logic [28:0] er;
    logic tk;
    int j;
    void'($urandom(32'h5df7));
    do_reset();
    // Reset values and refused accesses
    axi_rd(A_REGS, d, r);
    `CHK("reset sp i", 9'h1ff, {d[27], d[23:16]})
    axi_rd(A_START, d, r);
    `CHK("start reset", 16'h0000, d[15:0])
    axi_rd(8'h20, d, r);
    `CHK("unmapped rd", {RESP_SLVERR, 32'h0}, {r, d})
    axi_wr(8'h24, 32'h1, r);
    `CHK("unmapped wr", RESP_SLVERR, r)
    axi_wr(A_PC, 32'hffff, r);
    `CHK("pc write", RESP_OKAY, r)
    $display("test registers done");
    for (int k = 0; k < 8; k++)
    begin
      a0 = 8'($urandom);
      x0 = 8'($urandom);
      ii = 8'($urandom);
      jj = 8'($urandom);
      cc = 8'($urandom);
      op = 8'($urandom) & 8'h0f;
      // Corner: borrow out of the first subtract into the second
      if (k == 0)
      begin
        a0 = 8'h00;
        ii = 8'h01;
      end
      do_reset();
      // Stack frame pops into state, then code at 0300
      prog = '{8'ha0, ii, 8'ha2, jj, 8'hb7, 8'h40, 8'hbf, 8'h41, 8'h36, 8'h40, 8'h9b, 8'h9c, op,
               8'h40, 8'h02, 8'hbf, 8'h50, 8'hcc, 8'h03, 8'h16, 8'hbf, 8'h52, 8'hbf, 8'h51, 8'h8e,
               8'h20, 8'hfe};
      for (j = 0; j < 27; j++)
        cbsi_mem_model_inst.mem[16'h0300 + 16'(j)] = prog[j];
      cbsi_mem_model_inst.mem[16'h0000] = cc;
      cbsi_mem_model_inst.mem[16'h0001] = a0;
      cbsi_mem_model_inst.mem[16'h0002] = x0;
      cbsi_mem_model_inst.mem[16'h0003] = 8'h03;
      cbsi_mem_model_inst.mem[16'h0004] = 8'h00;
      cbsi_mem_model_inst.mem[16'h0200] = 8'h80;
      cbsi_mem_model_inst.mem[16'h0050] = ~x0;
      cbsi_mem_model_inst.mem[16'h0052] = ~x0;
      axi_wr(A_START, 32'h0200, r);
      axi_wr(A_CTRL, 32'h1, r);
      for (j = 0; j < 300 && osc_stop !== 1'h1; j++)
        @(posedge aclk);
      `CHK("osc_stop", 1'h1, osc_stop)
      `CHK("irq_pin_en", 1'h1, irq_pin_en)
      axi_rd(A_STATUS, d, r);
      `CHK("stopped", 1'h1, d[ST_STOP])
      // Pin low wakes the core after the synchroniser
      irq_pin <= 1'h0;
      for (j = 0; j < 20 && osc_stop !== 1'h0; j++)
        @(posedge aclk);
      irq_pin <= 1'h1;
      `CHK("woken", 1'h0, osc_stop)
      ref_run(a0, x0, ii, jj, cc, op, er, em, tk);
      axi_rd(A_REGS, d, r);
      `CHK("acc", er[7:0], d[7:0])
      `CHK("index", er[15:8], d[15:8])
      `CHK("sp", er[23:16], d[23:16])
      `CHK("flags", er[28:24], d[28:24])
      `CHK("rotated", em, cbsi_mem_model_inst.mem[16'h0040])
      `CHK("x stored", x0, cbsi_mem_model_inst.mem[16'h0041])
      `CHK("bit branch", tk ? ~x0 : x0, cbsi_mem_model_inst.mem[16'h0050])
      `CHK("jump skip", ~x0, cbsi_mem_model_inst.mem[16'h0052])
      `CHK("after jump", x0, cbsi_mem_model_inst.mem[16'h0051])
      $display("test program %0d done", k);
    end
    results();
  end

  // Watchdog: eight short programs need far fewer cycles than this
  initial
  begin
    #400000;
    n_errors++;
    $display("[ERR] watchdog exp done got hang");
    results();
  end
endmodule // testbench
